// *** hdl/ctcc_top.v ***
/*
 * Counter/timer capture and control block: eight-bit timer with control
 * register, capture registers of both timers and the wide hold register,
 * all reached by software over AXI4-Lite.
 * Assumes one 100 MHz clock, a synchronous active-high reset and inputs
 * synchronous to that clock. The sixteen-bit counter itself lives
 * outside; its count and capture strobe arrive as plain inputs.
 */
// Implementation choice: register access over AXI4-Lite.
`timescale 1ns/10ps
`include "ctcc_regs.vh"

// Behaviour
// - high-phase count readable in capture high
// - low-phase count readable in capture low
// - wide capture MSB in its register
// - wide capture LSB in its register
// - writes to capture registers ignored
// - wide hold MSB register read/write
// - control bit 1 gates timeout interrupt
// - control bit 0 routes timer to pin
// - writing enable 1 starts timer
// - mode 0 reloads and keeps counting
// - mode 1 halts at terminal count
// - terminal count sets timeout flag
// - timeout flag cleared only by one
// - first count tick may be short
// - wrap to all-ones is no timeout
// - clock field selects count rate
// - start/stop acts one count tick later
module ctcc_top #(
    parameter ADDR_W = 8
) (
    input  wire              ref_clk,
    input  wire              srst,
    // AXI4-Lite slave
    input  wire [ADDR_W-1:0] s_axi_awaddr,
    input  wire              s_axi_awvalid,
    output reg               s_axi_awready,
    input  wire [31:0]       s_axi_wdata,
    input  wire [3:0]        s_axi_wstrb,
    input  wire              s_axi_wvalid,
    output reg               s_axi_wready,
    output reg  [1:0]        s_axi_bresp,
    output reg               s_axi_bvalid,
    input  wire              s_axi_bready,
    input  wire [ADDR_W-1:0] s_axi_araddr,
    input  wire              s_axi_arvalid,
    output reg               s_axi_arready,
    output reg  [31:0]       s_axi_rdata,
    output reg  [1:0]        s_axi_rresp,
    output reg               s_axi_rvalid,
    input  wire              s_axi_rready,
    // Timer side
    input  wire              meas_in,
    input  wire              cap16_stb,
    input  wire [15:0]       count16,
    input  wire              port3_pin4_port_data,
    output reg               port3_pin4,
    output reg               timer8_irq_q,
    output reg  [7:0]        wide_hold_msb_q
);

    // ------------------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------------------
    reg  [7:0]        ctl_q;          // Control bits other than run state
    reg               run_q;          // Counter actually running
    reg               run_req_q;      // Requested run state, applied on a tick
    reg               timeout_q;
    reg  [7:0]        reload_q;
    reg  [7:0]        count_q;
    reg               t8_out_q;
    reg  [ADDR_W-1:0] aw_q;
    reg               aw_have_q;
    reg  [31:0]       wd_q;
    reg  [3:0]        ws_q;
    reg               w_have_q;
    reg  [31:0]       rd_d;
    reg               rd_ok;
    wire              tick;
    wire [7:0]        high_phase_count;
    wire [7:0]        low_phase_count;
    wire [15:0]       wide_capture;
    wire              do_write;
    wire [3:0]        w_idx;
    wire [3:0]        r_idx;
    wire              w_map;
    wire              ctl_wr;
    wire              terminal;

    // ------------------------------------------------------------------------
    // Submodules
    // ------------------------------------------------------------------------
    // clock select
    ctcc_prescaler u_presc (
        .ref_clk (ref_clk),
        .srst    (srst),
        .clk_sel (ctl_q[`CTCC_CTL_CLK_HI:`CTCC_CTL_CLK_LO]),
        .tick_q  (tick)
    );

    ctcc_capture #(
        .W8 (8)
    ) u_cap (
        .ref_clk            (ref_clk),
        .srst               (srst),
        .meas_in            (meas_in),
        .cap16_stb          (cap16_stb),
        .count16            (count16),
        .high_phase_count_q (high_phase_count),
        .low_phase_count_q  (low_phase_count),
        .wide_capture_q     (wide_capture)
    );

    // ------------------------------------------------------------------------
    // AXI write channel
    // ------------------------------------------------------------------------
    // Address and data are taken in either order, then one response
    assign do_write = aw_have_q && w_have_q && !s_axi_bvalid;
    assign w_idx    = aw_q[5:2];
    assign w_map    = (aw_q[ADDR_W-1:6] == {(ADDR_W-6){1'b0}}) &&
                      (w_idx <= `CTCC_IDX_TIMER8_CAP_HI);
    assign ctl_wr   = do_write && w_map && ws_q[0] &&
                      (w_idx == `CTCC_IDX_TIMER8_CONTROL);

    always @(posedge ref_clk) begin
        if (srst) begin
            s_axi_awready <= 1'b1;
            s_axi_wready  <= 1'b1;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= `CTCC_RESP_OKAY;
            aw_have_q     <= 1'b0;
            w_have_q      <= 1'b0;
            aw_q          <= {ADDR_W{1'b0}};
            wd_q          <= 32'h00000000;
            ws_q          <= 4'h0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_q          <= s_axi_awaddr;
                aw_have_q     <= 1'b1;
                s_axi_awready <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                wd_q         <= s_axi_wdata;
                ws_q         <= s_axi_wstrb;
                w_have_q     <= 1'b1;
                s_axi_wready <= 1'b0;
            end
            if (do_write) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= w_map ? `CTCC_RESP_OKAY : `CTCC_RESP_SLVERR;
                aw_have_q    <= 1'b0;
                w_have_q     <= 1'b0;
            end
            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid  <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready  <= 1'b1;
            end
        end
    end

    // ------------------------------------------------------------------------
    // Writable registers
    // ------------------------------------------------------------------------
    // capture offsets have no write path at all
    always @(posedge ref_clk) begin
        if (srst) begin
            ctl_q           <= `CTCC_CTL_RESET;
            reload_q        <= `CTCC_RELOAD_RESET;
            wide_hold_msb_q <= 8'h00;
            run_req_q       <= 1'b0;
        end else begin
            if (ctl_wr) begin
                // pin, mask, clock and mode bits
                ctl_q <= wd_q[7:0];
                run_req_q <= wd_q[`CTCC_CTL_ENABLE];
            end else if (run_q && terminal && ctl_q[`CTCC_CTL_SINGLE]) begin
                run_req_q <= 1'b0;
            end
            if (do_write && w_map && ws_q[0] &&
                w_idx == `CTCC_IDX_TIMER8_RELOAD)
                reload_q <= wd_q[7:0];
            if (do_write && w_map && ws_q[0] &&
                w_idx == `CTCC_IDX_TIMER16_HOLD_HI)
                wide_hold_msb_q <= wd_q[7:0];
        end
    end

    // ------------------------------------------------------------------------
    // Eight-bit counter
    // ------------------------------------------------------------------------
    // only a count of one stepping down is terminal, not 0 to all-ones
    assign terminal = tick && (count_q == 8'h01);

    always @(posedge ref_clk) begin
        if (srst) begin
            run_q    <= 1'b0;
            count_q  <= 8'h00;
            t8_out_q <= 1'b0;
        end else if (tick) begin
            // run state follows the request one tick later
            // tick phase is free running, first period may be short
            if (run_req_q && !run_q) begin
                run_q   <= 1'b1;
                count_q <= reload_q;         // Fresh start reloads the count
            end else if (!run_req_q) begin
                run_q <= 1'b0;
            end else if (count_q == 8'h01) begin
                t8_out_q <= ~t8_out_q;
                if (ctl_q[`CTCC_CTL_SINGLE]) begin
                    run_q   <= 1'b0;
                    count_q <= 8'h00;
                end else begin
                    count_q <= reload_q;
                end
            end else begin
                count_q <= count_q - 8'h01;
            end
        end
    end

    // ------------------------------------------------------------------------
    // Timeout flag and interrupt
    // ------------------------------------------------------------------------
    always @(posedge ref_clk) begin
        if (srst) begin
            timeout_q <= 1'b0;
        end else if (run_q && run_req_q && terminal) begin
            // set wins over a simultaneous clear
            timeout_q <= 1'b1;
        end else if (ctl_wr && wd_q[`CTCC_CTL_TIMEOUT]) begin
            timeout_q <= 1'b0;
        end
    end

    // Registered so the output comes straight from a flip-flop
    always @(posedge ref_clk) begin
        if (srst)
            timer8_irq_q <= 1'b0;
        else
            timer8_irq_q <= timeout_q & ctl_q[`CTCC_CTL_IRQ_EN];
    end

    // ------------------------------------------------------------------------
    // Pin output
    // ------------------------------------------------------------------------
    always @(posedge ref_clk) begin
        if (srst)
            port3_pin4 <= 1'b0;
        else
            port3_pin4 <= ctl_q[`CTCC_CTL_PIN_SEL] ? t8_out_q : port3_pin4_port_data;
    end

    // ------------------------------------------------------------------------
    // AXI read channel
    // ------------------------------------------------------------------------
    assign r_idx = s_axi_araddr[5:2];

    always @* begin
        rd_d  = 32'h00000000;
        rd_ok = (s_axi_araddr[ADDR_W-1:6] == {(ADDR_W-6){1'b0}});
        case (r_idx)
            `CTCC_IDX_TIMER8_CONTROL:  rd_d[7:0] = {run_req_q, ctl_q[6],
                                                   timeout_q, ctl_q[4:0]};
            `CTCC_IDX_TIMER8_RELOAD:   rd_d[7:0] = reload_q;
            `CTCC_IDX_TIMER8_COUNT:    rd_d[7:0] = count_q;
            `CTCC_IDX_TIMER16_HOLD_HI: rd_d[7:0] = wide_hold_msb_q;
            `CTCC_IDX_TIMER16_CAP_LO:  rd_d[7:0] = wide_capture[7:0];
            `CTCC_IDX_TIMER16_CAP_HI:  rd_d[7:0] = wide_capture[15:8];
            `CTCC_IDX_TIMER8_CAP_LO:   rd_d[7:0] = low_phase_count;
            `CTCC_IDX_TIMER8_CAP_HI:   rd_d[7:0] = high_phase_count;
            4'h3, 4'h4, 4'h5, 4'h6:    rd_d = 32'h00000000;
            default:                   rd_ok = 1'b0;
        endcase
    end

    always @(posedge ref_clk) begin
        if (srst) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h00000000;
            s_axi_rresp   <= `CTCC_RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b1;
            s_axi_rdata   <= rd_ok ? rd_d : 32'h00000000;
            s_axi_rresp   <= rd_ok ? `CTCC_RESP_OKAY : `CTCC_RESP_SLVERR;
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid  <= 1'b0;
            s_axi_arready <= 1'b1;
        end
    end

endmodule // ctcc_top

// *** shared/ctcc_regs.vh ***
/*
 * Register map, field positions, reset values and timing counts of the
 * counter/timer capture and control block.
 * Assumes byte offsets on a 32-bit AXI4-Lite bus, one register per word.
 */
`ifndef CTCC_REGS_VH
`define CTCC_REGS_VH

// ----------------------------------------------------------------------------
// Register indices (word index, byte address is four times this)
// ----------------------------------------------------------------------------
`define CTCC_IDX_TIMER8_CONTROL   4'h0
`define CTCC_IDX_TIMER8_RELOAD    4'h1
`define CTCC_IDX_TIMER8_COUNT     4'h2
`define CTCC_IDX_TIMER16_HOLD_HI  4'h7
`define CTCC_IDX_TIMER16_CAP_LO   4'h8
`define CTCC_IDX_TIMER16_CAP_HI   4'h9
`define CTCC_IDX_TIMER8_CAP_LO    4'ha
`define CTCC_IDX_TIMER8_CAP_HI    4'hb

// ----------------------------------------------------------------------------
// Control register fields
// ----------------------------------------------------------------------------
`define CTCC_CTL_ENABLE   7
`define CTCC_CTL_SINGLE   6
`define CTCC_CTL_TIMEOUT  5
`define CTCC_CTL_CLK_HI   4
`define CTCC_CTL_CLK_LO   3
`define CTCC_CTL_IRQ_EN   1
`define CTCC_CTL_PIN_SEL  0

// ----------------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------------
`define CTCC_CTL_RESET    8'h00
`define CTCC_RELOAD_RESET 8'hff

// ----------------------------------------------------------------------------
// Prescaler terminal counts (divide ratio minus one) for the four clock selections
// ----------------------------------------------------------------------------
`define CTCC_DIV_SEL0     8'h01
`define CTCC_DIV_SEL1     8'h03
`define CTCC_DIV_SEL2     8'h07
`define CTCC_DIV_SEL3     8'h0f

// AXI response codes
`define CTCC_RESP_OKAY    2'b00
`define CTCC_RESP_SLVERR  2'b10

`endif

// *** hdl/ctcc_prescaler.v ***
/*
 * Free-running prescaler that gives one-cycle count enables for the
 * eight-bit timer at a selectable rate.
 * Assumes a single system clock; the divider never stops, so the first
 * enable after a timer start lands at an arbitrary moment.
 */
`timescale 1ns/10ps
`include "ctcc_regs.vh"

module ctcc_prescaler (
    input  wire       ref_clk,
    input  wire       srst,
    input  wire [1:0] clk_sel,
    output reg        tick_q
);

    reg  [7:0] div_q;
    reg  [7:0] limit;

    // ------------------------------------------------------------------------
    // Divide ratio
    // ------------------------------------------------------------------------
    always @* begin
        case (clk_sel)
            2'b00:   limit = `CTCC_DIV_SEL0;
            2'b01:   limit = `CTCC_DIV_SEL1;
            2'b10:   limit = `CTCC_DIV_SEL2;
            default: limit = `CTCC_DIV_SEL3;
        endcase
    end

    // ------------------------------------------------------------------------
    // Divider
    // ------------------------------------------------------------------------
    // Free running on purpose: a partial first period is accepted
    always @(posedge ref_clk) begin
        if (srst) begin
            div_q  <= 8'h00;
            tick_q <= 1'b0;
        end else if (div_q >= limit) begin
            div_q  <= 8'h00;
            tick_q <= 1'b1;
        end else begin
            div_q  <= div_q + 8'h01;
            tick_q <= 1'b0;
        end
    end

endmodule // ctcc_prescaler

// *** hdl/ctcc_capture.v ***
/*
 * Capture logic: counts system clocks while the measured input is high
 * and while it is low, and latches the sixteen-bit timer count on a strobe.
 * Assumes meas_in and cap16_stb are synchronous to ref_clk.
 */
`timescale 1ns/10ps

module ctcc_capture #(
    parameter W8 = 8
) (
    input  wire          ref_clk,
    input  wire          srst,
    input  wire          meas_in,
    input  wire          cap16_stb,
    input  wire [15:0]   count16,
    output reg  [W8-1:0] high_phase_count_q,
    output reg  [W8-1:0] low_phase_count_q,
    output reg  [15:0]   wide_capture_q
);

    reg           meas_q;
    reg  [W8-1:0] run_q;

    // ------------------------------------------------------------------------
    // Phase counters
    // ------------------------------------------------------------------------
    // A phase count is latched on each edge of the measured input
    always @(posedge ref_clk) begin
        if (srst) begin
            meas_q             <= 1'b0;
            run_q              <= {W8{1'b0}};
            high_phase_count_q <= {W8{1'b0}};
            low_phase_count_q  <= {W8{1'b0}};
        end else begin
            meas_q <= meas_in;
            if (meas_in != meas_q) begin
                run_q <= {{(W8-1){1'b0}}, 1'b1};
                if (meas_q)
                    high_phase_count_q <= run_q;
                else
                    low_phase_count_q <= run_q;
            end else if (run_q != {W8{1'b1}}) begin
                run_q <= run_q + {{(W8-1){1'b0}}, 1'b1};  // Saturate, no wrap
            end
        end
    end

    // ------------------------------------------------------------------------
    // Wide capture
    // ------------------------------------------------------------------------
    always @(posedge ref_clk) begin
        if (srst)
            wide_capture_q <= 16'h0000;
        else if (cap16_stb)
            wide_capture_q <= count16;
    end

endmodule // ctcc_capture

// *** sim/ctcc_monitor.sv ***
/* Port checker for the counter/timer capture and control block.
   Assumes one clock, synchronous active-high reset; bound from the bench. */
`timescale 1ns/10ps

module ctcc_monitor (
    input wire        ref_clk,
    input wire        srst,
    input wire        s_axi_awvalid,
    input wire        s_axi_awready,
    input wire        s_axi_wvalid,
    input wire        s_axi_wready,
    input wire [1:0]  s_axi_bresp,
    input wire        s_axi_bvalid,
    input wire        s_axi_bready,
    input wire        s_axi_arvalid,
    input wire        s_axi_arready,
    input wire [31:0] s_axi_rdata,
    input wire [1:0]  s_axi_rresp,
    input wire        s_axi_rvalid,
    input wire        s_axi_rready,
    input wire        port3_pin4,
    input wire        timer8_irq_q,
    input wire [7:0]  wide_hold_msb_q
);
    reg [7:0] wr_age_q;
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (srst);
    // Cycles since the last write address was taken, saturating
    always @(posedge ref_clk) begin
        if (srst) begin
            wr_age_q <= 8'hff;
        end else if (s_axi_awvalid && s_axi_awready) begin
            wr_age_q <= 8'h00;
        end else if (wr_age_q != 8'hff) begin
            wr_age_q <= wr_age_q + 8'h01;
        end
    end
    reset_values_a: assert property ($past(srst) |-> !s_axi_bvalid && !s_axi_rvalid
        && !timer8_irq_q && !port3_pin4 && wide_hold_msb_q == 8'h00 && s_axi_awready)
        else $error("outputs not at reset values");
    bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped early");
    rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped early");
    read_latency_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read answer late");
    write_latency_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
        && s_axi_wready |-> ##[1:2] s_axi_bvalid) else $error("write answer late");
    write_busy_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write ready during response");
    read_busy_a: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read ready during response");
    upper_zero_a: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h000000)
        else $error("upper read bits not zero");
    err_data_a: assert property (s_axi_rvalid && s_axi_rresp == 2'h2 |-> s_axi_rdata == 32'h0)
        else $error("error read returned data");
    irq_drop_a: assert property ($fell(timer8_irq_q) |-> wr_age_q <= 8'h04)
        else $error("interrupt dropped without a write");
    hold_change_a: assert property (!$stable(wide_hold_msb_q) |-> wr_age_q <= 8'h03)
        else $error("hold register changed without a write");
endmodule // ctcc_monitor

// *** sim/ctcc_top_tb.sv ***
/* Self-checking bench of the counter/timer block: AXI4-Lite master tasks
   and one task per scenario. Assumes the register map in ctcc_regs.vh. */
`timescale 1ns/10ps
`include "ctcc_regs.vh"

module ctcc_top_tb;
    reg          ref_clk = 1'h0;
    reg          srst    = 1'h1;
    reg  [7:0]   awaddr  = 8'h00;
    reg          awvalid = 1'h0;
    reg  [31:0]  wdata   = 32'h0;
    reg  [3:0]   wstrb   = 4'h0;
    reg          wvalid  = 1'h0;
    reg          bready  = 1'h0;
    reg  [7:0]   araddr  = 8'h00;
    reg          arvalid = 1'h0;
    reg          rready  = 1'h0;
    reg          meas_in = 1'h0;
    reg          cap_stb = 1'h0;
    reg  [15:0]  count16 = 16'h0000;
    reg          pdata   = 1'h0;
    wire         awready, wready, bvalid, arready, rvalid, pin, irq;
    wire [1:0]   bresp, rresp;
    wire [31:0]  rdata;
    wire [7:0]   hold;
    int          n_mismatch = 0;
    int          checks_done = 0;
    logic [31:0] rd;
    logic [1:0]  rs;
    // Free-running 100 MHz clock
    always #5 ref_clk = ~ref_clk;
    ctcc_top dut_u (.ref_clk(ref_clk), .srst(srst), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .meas_in(meas_in), .cap16_stb(cap_stb), .count16(count16),
        .port3_pin4_port_data(pdata), .port3_pin4(pin), .timer8_irq_q(irq),
        .wide_hold_msb_q(hold));
    // ------------------------------------------------------------------
    // Reporting and compare tasks
    // ------------------------------------------------------------------
    task print_verdict;
        $display("checks %0d mismatches %0d", checks_done, n_mismatch);
        if (n_mismatch == 0 && checks_done > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    task chk32(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            n_mismatch++;
            $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task chk1(input logic got, input logic exp);
        chk32({31'h0, got}, {31'h0, exp});
    endtask
    task chk_resp(input logic [1:0] exp);
        chk32({30'h0, rs}, {30'h0, exp});
    endtask
    // A wait that runs out ends the run at once
    task bound(input int n);
        if (n >= 400) begin
            n_mismatch++;
            $display("MISMATCH at %0t: wait ran out", $time);
            print_verdict();
        end
    endtask
    // ------------------------------------------------------------------
    // AXI4-Lite master: hold each channel until its own ready
    // ------------------------------------------------------------------
    task axi_wr(input logic [7:0] a, input logic [7:0] d);
        int   n;
        logic b_ok;
        n = 0;
        b_ok = 1'h0;
        @(posedge ref_clk);
        awaddr <= a;
        wdata <= {24'h0, d};
        wstrb <= 4'hf;
        awvalid <= 1'h1;
        wvalid <= 1'h1;
        bready <= 1'h1;
        while (!b_ok && n < 400) begin
            @(posedge ref_clk);
            n++;
            if (awvalid && awready) awvalid <= 1'h0;
            if (wvalid && wready) wvalid <= 1'h0;
            if (bvalid) begin
                rs = bresp;
                b_ok = 1'h1;
            end
        end
        bready <= 1'h0;
        bound(n);
    endtask
    task axi_rd(input logic [7:0] a);
        int   n;
        logic r_ok;
        n = 0;
        r_ok = 1'h0;
        @(posedge ref_clk);
        araddr <= a;
        arvalid <= 1'h1;
        rready <= 1'h1;
        while (!r_ok && n < 400) begin
            @(posedge ref_clk);
            n++;
            if (arvalid && arready) arvalid <= 1'h0;
            if (rvalid) begin
                rd = rdata;
                rs = rresp;
                r_ok = 1'h1;
            end
        end
        rready <= 1'h0;
        bound(n);
    endtask
    // Cycles between two pin toggles; the first, possibly short, is skipped
    task toggle_gap(output int n);
        logic p;
        for (int k = 0; k < 2; k++) begin
            p = pin;
            n = 0;
            while (pin === p && n < 400) begin
                @(posedge ref_clk);
                n++;
            end
            bound(n);
        end
    endtask
    // ------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------
    task t_reset_and_regs;
        axi_rd(8'h00);
        chk32(rd, 32'h00); // control at reset
        chk1(pin, 1'h0);
        chk1(irq, 1'h0);
        axi_wr(8'h1c, 8'ha5);
        chk_resp(`CTCC_RESP_OKAY);
        axi_rd(8'h1c);
        chk32(rd, 32'ha5);
        chk32({24'h0, hold}, 32'ha5);
        axi_rd(8'h30);
        chk_resp(`CTCC_RESP_SLVERR);
        axi_wr(8'h30, 8'h11);
        chk_resp(`CTCC_RESP_SLVERR);
        // Pin follows port data while the timer output is not selected
        @(posedge ref_clk) pdata <= 1'h1;
        repeat (3) @(posedge ref_clk);
        chk1(pin, 1'h1);
        pdata <= 1'h0;
        repeat (3) @(posedge ref_clk);
        chk1(pin, 1'h0);
    endtask
    task t_captures;
        @(posedge ref_clk) count16 <= 16'hbe37;
        cap_stb <= 1'h1;
        @(posedge ref_clk) cap_stb <= 1'h0;
        count16 <= 16'h4c21;
        axi_rd(8'h20);
        chk32(rd, 32'h37);
        axi_rd(8'h24);
        chk32(rd, 32'hbe);
        axi_wr(8'h20, 8'h00);
        chk_resp(`CTCC_RESP_OKAY);
        axi_rd(8'h20);
        chk32(rd, 32'h37);
        // Long low phase saturates, short high phase of five clocks
        repeat (300) @(posedge ref_clk);
        meas_in <= 1'h1;
        repeat (5) @(posedge ref_clk);
        meas_in <= 1'h0;
        repeat (300) @(posedge ref_clk);
        axi_rd(8'h2c);
        chk32(rd, 32'h05);
        axi_rd(8'h28);
        chk32(rd, 32'hff);
    endtask
    task t_single_pass;
        int n;
        n = 0;
        axi_wr(8'h04, 8'h03);
        axi_wr(8'h00, 8'h20); // flag cleared before use
        axi_wr(8'h00, 8'hc3);
        rd = 32'h0;
        while (!rd[5] && n < 400) begin
            axi_rd(8'h00);
            n++;
        end
        bound(n);
        chk32(rd, 32'h63);
        repeat (2) @(posedge ref_clk);
        chk1(irq, 1'h1);
        axi_wr(8'h00, 8'h43); // whole value, no read-modify-write
        axi_rd(8'h00);
        chk32(rd, 32'h63); // zero leaves flag
        axi_wr(8'h00, 8'h41);
        repeat (2) @(posedge ref_clk);
        chk1(irq, 1'h0);
        axi_wr(8'h00, 8'h21);
        repeat (100) @(posedge ref_clk);
        axi_rd(8'h00);
        chk32(rd, 32'h01); // stays halted
        // A start from zero wraps to all-ones without a timeout
        axi_wr(8'h04, 8'h00);
        axi_wr(8'h00, 8'h81);
        repeat (20) @(posedge ref_clk);
        axi_rd(8'h00);
        chk32(rd, 32'h81); // no timeout on wrap
        axi_rd(8'h08);
        chk1(rd >= 32'he0, 1'h1); // count wrapped
        axi_wr(8'h00, 8'h01); // stop first
    endtask
    task t_modulo_rates;
        int         n;
        logic [7:0] cb;
        for (int s = 0; s < 4; s++) begin
            cb = {3'h0, s[1:0], 3'h0};
            axi_wr(8'h04, 8'h03);
            axi_wr(8'h00, 8'h81 | cb);
            toggle_gap(n); // short first gap skipped
            chk32(n, 3 * (2 << s));
            axi_rd(8'h00);
            chk32(rd, {24'h0, 8'ha1 | cb});
            chk1(irq, 1'h0);
            axi_wr(8'h00, cb | 8'h01); // stop first
            axi_wr(8'h00, 8'h21); // clear later
        end
    endtask
    // Main sequence: reset for 20 cycles, then every scenario
    initial begin
        repeat (20) @(posedge ref_clk);
        srst <= 1'h0;
        t_reset_and_regs();
        t_captures();
        t_single_pass();
        t_modulo_rates();
        print_verdict();
    end
endmodule // ctcc_top_tb

bind ctcc_top ctcc_monitor mon_u (.ref_clk(ref_clk), .srst(srst),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .port3_pin4(port3_pin4),
    .timer8_irq_q(timer8_irq_q), .wide_hold_msb_q(wide_hold_msb_q));
